/* File: uart_receive_status_flags.sv */
// UART receive status flags with APB access and one interrupt output.
//
// Implementation choice: the APB slave port.
`timescale 1ns/1ps
`default_nettype none
// How it works
// RULE1: A received byte raises the byte-waiting flag in bit 7 and a read of the receive data register clears it.
// RULE2: A frame failing its parity check raises the parity error flag in bit 6, cleared by a receive data read.
// RULE3: A frame with no stop bit raises the framing error flag in bit 4, cleared by a receive data read.
// RULE4: A frame whose data, ninth bit and stop bit are all zero raises the break flag in bit 3, cleared by a receive data read.
// RULE5: A frame completing while the previous byte is unread raises the overrun flag in bit 5, cleared by a receive data read.
// RULE6: The receive data address reads received data and its writes go to the transmitter instead.
module uart_receive_status_flags
   import rx_status_pkg::*;
(
   // Clock, reset and enable.
   input wire logic CLK,
   input wire logic RST_N,
   input wire logic CE,
   // APB slave.
   input wire rx_status_pkg::apb_req_t APB_REQ,
   output var rx_status_pkg::apb_rsp_t APB_RSP,
   // Completed frame from the receive shifter.
   input wire rx_status_pkg::rx_frame_t RX,
   // Byte for the transmitter.
   output logic [7:0] TX_DATA,
   output logic TX_WRITE,
   // Interrupt.
   output logic IRQ
);
   import rx_status_pkg::*;

   state_t q;
   state_t d;
   logic setup;
   logic access;
   logic rd_data;
   logic wr_int_status;
   logic brk_frame;
   logic [EV_N-1:0] ev;
   logic [7:0] line_status;

   // Matches the bus address against a register index.
   function automatic logic addr_is(input logic [ADDR_W-1:0] a,
                                    input logic [11:0] idx);
      addr_is = (a == {2'b00, idx, 2'b00});
   endfunction

   always_comb begin
      setup = APB_REQ.psel & ~APB_REQ.penable;
      access = APB_REQ.psel & APB_REQ.penable;
      rd_data = access & ~APB_REQ.pwrite & addr_is(APB_REQ.paddr, IDX_RX_DATA);
      wr_int_status = access & APB_REQ.pwrite
                      & addr_is(APB_REQ.paddr, IDX_INT_STATUS);
      brk_frame = RX.done & (RX.data == 8'h00) & ~RX.ninth_bit
                  & ~RX.stop_high;
      line_status = {q.receive_byte_waiting, q.parity_error, q.overrun,
                     q.framing_error, q.break_detected, 3'b000};
      ev = {RX.done,
            RX.done & RX.parity_fail,
            RX.done & q.receive_byte_waiting & ~rd_data,
            RX.done & ~RX.stop_high,
            brk_frame};
   end

   always_comb begin
      d = q;
      d.tx_write = 1'b0;
      // A new frame wins over a clearing read in the same cycle.
      d.receive_byte_waiting = RX.done
                               | (q.receive_byte_waiting & ~rd_data); // RULE1
      d.parity_error = ev[BIT_PARITY-EV_LSB]
                       | (q.parity_error & ~rd_data); // RULE2
      d.framing_error = ev[BIT_FRAMING-EV_LSB]
                        | (q.framing_error & ~rd_data); // RULE3
      d.break_detected = brk_frame | (q.break_detected & ~rd_data); // RULE4
      d.overrun = ev[BIT_OVERRUN-EV_LSB] | (q.overrun & ~rd_data); // RULE5
      if (RX.done) begin
         d.rx_data = RX.data;
      end
      for (int i = 0; i < EV_N; i++) begin
         d.int_status[i] = ev[i] | (q.int_status[i]
                           & ~(wr_int_status & APB_REQ.pwdata[i+EV_LSB]));
      end
      // Read data and error are captured in the setup cycle.
      if (setup) begin
         d.pslverr = 1'b0;
         d.prdata = 32'h0000_0000;
         if (addr_is(APB_REQ.paddr, IDX_RX_DATA)) begin
            d.prdata = {24'h00_0000, q.rx_data}; // RULE6
         end else if (addr_is(APB_REQ.paddr, IDX_RX_STATUS)) begin
            d.prdata = {24'h00_0000, line_status};
         end else if (addr_is(APB_REQ.paddr, IDX_INT_STATUS)) begin
            d.prdata = {24'h00_0000, q.int_status, 3'b000};
         end else if (addr_is(APB_REQ.paddr, IDX_INT_MASK)) begin
            d.prdata = {24'h00_0000, q.int_mask, 3'b000};
         end else begin
            d.pslverr = 1'b1;
         end
      end
      if (access & APB_REQ.pwrite) begin
         if (addr_is(APB_REQ.paddr, IDX_RX_DATA)) begin
            d.tx_data = APB_REQ.pwdata[7:0]; // RULE6
            d.tx_write = 1'b1;
         end
         if (addr_is(APB_REQ.paddr, IDX_INT_MASK)) begin
            d.int_mask = APB_REQ.pwdata[EV_LSB+EV_N-1:EV_LSB];
         end
      end
   end

   always_ff @(posedge CLK or negedge RST_N) begin
      if (!RST_N) begin
         q <= STATE_RST;
      end else if (CE) begin
         q <= d;
      end
   end

   assign APB_RSP.prdata = q.prdata;
   assign APB_RSP.pready = CE;
   assign APB_RSP.pslverr = q.pslverr;
   assign TX_DATA = q.tx_data;
   assign TX_WRITE = q.tx_write;
   assign IRQ = |(q.int_status & q.int_mask);

   default clocking cb @(posedge CLK);
   endclocking
   default disable iff (!RST_N);

   sequence s_frame;
      CE && RX.done;
   endsequence

   sequence s_data_read;
      CE && rd_data;
   endsequence

   sequence s_data_write;
      CE && access && APB_REQ.pwrite
      && addr_is(APB_REQ.paddr, IDX_RX_DATA);
   endsequence

   byte_waiting_set_a: assert property (s_frame |=> q.receive_byte_waiting) // RULE1
      else $error("Byte waiting flag not set after a frame.");
   byte_waiting_clr_a: assert property ((s_data_read and !RX.done) // RULE1
      |=> !q.receive_byte_waiting && !q.parity_error && !q.overrun)
      else $error("Receive data read did not clear the flags.");
   parity_set_a: assert property ((s_frame and RX.parity_fail) // RULE2
      |=> q.parity_error && q.int_status[BIT_PARITY-EV_LSB])
      else $error("Parity error flag not set.");
   framing_set_a: assert property ((s_frame and !RX.stop_high) // RULE3
      |=> q.framing_error)
      else $error("Framing error flag not set.");
   break_flag_a: assert property (s_frame |=> // RULE4
      q.break_detected == ($past(RX.data) == 8'h00 && !$past(RX.ninth_bit)
      && !$past(RX.stop_high)) || $past(q.break_detected && !rd_data))
      else $error("Break flag does not match the frame.");
   overrun_set_a: assert property ((s_frame and q.receive_byte_waiting // RULE5
      and !rd_data) |=> q.overrun ##0 q.receive_byte_waiting)
      else $error("Overrun flag not set on an unread byte.");
   tx_write_a: assert property (s_data_write |=> TX_WRITE // RULE6
      && TX_DATA == $past(APB_REQ.pwdata[7:0]))
      else $error("Write to data address did not reach the transmitter.");
   rx_read_a: assert property ((CE && setup && !APB_REQ.pwrite // RULE6
      && addr_is(APB_REQ.paddr, IDX_RX_DATA))
      |=> APB_RSP.prdata == {24'h00_0000, $past(q.rx_data)})
      else $error("Data address read did not return received data.");

endmodule
`default_nettype wire

/* File: rx_status_pkg.sv */
// Package with register map, field layout and carrier types for the block.
package rx_status_pkg;

   // Printed offsets are register indices; byte address is four times one.
   localparam logic [11:0] IDX_RX_DATA = 12'hF40;
   localparam logic [11:0] IDX_RX_STATUS = 12'hF41;
   localparam logic [11:0] IDX_INT_STATUS = 12'hF42;
   localparam logic [11:0] IDX_INT_MASK = 12'hF43;
   localparam int ADDR_W = 16;

   // Bit positions inside the line status, interrupt status and mask.
   localparam int BIT_BYTE_WAITING = 7;
   localparam int BIT_PARITY = 6;
   localparam int BIT_OVERRUN = 5;
   localparam int BIT_FRAMING = 4;
   localparam int BIT_BREAK = 3;
   localparam int EV_LSB = 3;
   localparam int EV_N = 5;

   // Values after reset.
   localparam logic [7:0] RST_RX_DATA = 8'h00;
   localparam logic [EV_N-1:0] RST_INT_MASK = 5'h00;
   localparam logic [EV_N-1:0] RST_INT_STATUS = 5'h00;

   typedef struct packed {
      logic psel;
      logic penable;
      logic pwrite;
      logic [ADDR_W-1:0] paddr;
      logic [31:0] pwdata;
   } apb_req_t;

   typedef struct packed {
      logic [31:0] prdata;
      logic pready;
      logic pslverr;
   } apb_rsp_t;

   typedef struct packed {
      logic done;
      logic [7:0] data;
      logic parity_fail;
      logic ninth_bit;
      logic stop_high;
   } rx_frame_t;

   typedef struct packed {
      logic receive_byte_waiting;
      logic parity_error;
      logic overrun;
      logic framing_error;
      logic break_detected;
      logic [7:0] rx_data;
      logic [EV_N-1:0] int_status;
      logic [EV_N-1:0] int_mask;
      logic [31:0] prdata;
      logic pslverr;
      logic [7:0] tx_data;
      logic tx_write;
   } state_t;

   localparam state_t STATE_RST = '{
      receive_byte_waiting: 1'b0,
      parity_error: 1'b0,
      overrun: 1'b0,
      framing_error: 1'b0,
      break_detected: 1'b0,
      rx_data: RST_RX_DATA,
      int_status: RST_INT_STATUS,
      int_mask: RST_INT_MASK,
      prdata: 32'h0000_0000,
      pslverr: 1'b0,
      tx_data: 8'h00,
      tx_write: 1'b0
   };

endpackage

/* File: frame_src.sv */
// Remote transmitter model handing completed frames to the block.
`timescale 1ns/1ps
`default_nettype none
module frame_src
   import rx_status_pkg::*;
(
   // Clock and reset.
   input wire logic clk,
   input wire logic rst_n,
   // Frame request from the bench.
   input wire logic send,
   input wire logic [10:0] fields,
   // Completed frame.
   output var rx_status_pkg::rx_frame_t rx
);
   import rx_status_pkg::*;
   // Outside a frame the fields show the inverse of their last value.
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         rx <= '0;
      end else if (send) begin
         rx <= {1'b1, fields};
      end else begin
         rx <= {1'b0, ~rx[10:0]};
      end
   end
endmodule
`default_nettype wire

/* File: uart_receive_status_flags_test.sv */
// Self-checking bench for the receive status flags block.
`timescale 1ns/1ps
`default_nettype none
`define CHK(a, e) begin tests_run++; if ((a) !== (e)) begin n_fail++; \
   $display("mismatch %0t got %h exp %h", $time, a, e); end end
module uart_receive_status_flags_test;
   import rx_status_pkg::*;
   localparam logic [15:0] A_DAT = {2'b00, IDX_RX_DATA, 2'b00};
   localparam logic [15:0] A_ST = {2'b00, IDX_RX_STATUS, 2'b00};
   localparam logic [15:0] A_IS = {2'b00, IDX_INT_STATUS, 2'b00};
   localparam logic [15:0] A_IM = {2'b00, IDX_INT_MASK, 2'b00};
   logic CLK = 1'b0;
   logic RST_N = 1'b0;
   apb_req_t req = '0;
   apb_rsp_t rsp;
   rx_frame_t rx;
   logic snd = 1'b0;
   logic [10:0] fl = '0;
   logic [7:0] tx_data;
   logic [7:0] last_tx = 8'h00;
   logic tx_write;
   logic irq;
   logic [31:0] rdat;
   logic rerr;
   logic [10:0] fv [3] = '{11'h1E5, 11'h2D0, 11'h000};
   logic [31:0] sv [3] = '{32'hC0, 32'h90, 32'h98};
   int n_fail = 0;
   int tests_run = 0;
   int tx_cnt = 0;
   always #5 CLK = ~CLK;
   frame_src far (.clk(CLK), .rst_n(RST_N), .send(snd), .fields(fl),
      .rx(rx));
   uart_receive_status_flags uut (.CLK(CLK), .RST_N(RST_N), .CE(1'b1),
      .APB_REQ(req), .APB_RSP(rsp), .RX(rx), .TX_DATA(tx_data),
      .TX_WRITE(tx_write), .IRQ(irq));
   always @(posedge CLK) begin
      if (tx_write === 1'b1) begin
         last_tx <= tx_data;
         tx_cnt <= tx_cnt + 1;
      end
   end
   task automatic xfer(input logic w, input logic [15:0] a,
      input logic [31:0] d);
      int n;
      n = 0;
      req <= '{psel: 1'b1, penable: 1'b0, pwrite: w, paddr: a, pwdata: d};
      @(posedge CLK);
      req.penable <= 1'b1;
      @(posedge CLK);
      while (rsp.pready !== 1'b1 && n < 20) begin
         n++;
         @(posedge CLK);
      end
      if (n >= 20) n_fail++;
      rdat = rsp.prdata;
      rerr = rsp.pslverr;
      req.psel <= 1'b0;
      req.penable <= 1'b0;
      @(posedge CLK);
   endtask
   task automatic rd(input logic [15:0] a, input logic [31:0] e);
      xfer(1'b0, a, 32'h0);
      `CHK(rdat, e)
   endtask
   task automatic frame(input logic [10:0] f);
      snd <= 1'b1;
      fl <= f;
      @(posedge CLK);
      snd <= 1'b0;
      repeat (3) @(posedge CLK);
   endtask
   task automatic conclude;
      $display("comparisons %0d mismatches %0d", tests_run, n_fail);
      if (n_fail == 0 && tests_run > 0) $display("Result: passed");
      else $display("Result: failed");
      $finish;
   endtask
   initial begin
      #20000;
      n_fail++;
      conclude();
   end
   initial begin
      repeat (5) @(posedge CLK);
      RST_N <= 1'b1;
      @(posedge CLK);
      rd(A_ST, 32'h0);
      rd(A_IM, 32'h0);
      rd(A_IS, 32'h0);
      `CHK(irq, 1'b0)
      $display("test reset done");
      frame({8'hA5, 3'b001});
      rd(A_ST, 32'h80);
      rd(A_DAT, 32'hA5);
      rd(A_ST, 32'h0);
      for (int i = 0; i < 3; i++) begin
         frame(fv[i]);
         rd(A_ST, sv[i]);
         rd(A_DAT, {24'h0, fv[i][10:3]});
         rd(A_ST, 32'h0);
      end
      $display("test error flags done");
      frame({8'h11, 3'b001});
      frame({8'h22, 3'b001});
      rd(A_ST, 32'hA0);
      rd(A_DAT, 32'h22);
      rd(A_ST, 32'h0);
      $display("test overrun done");
      xfer(1'b1, A_DAT, 32'h5E);
      @(posedge CLK);
      `CHK(last_tx, 8'h5E)
      `CHK(tx_cnt, 1)
      xfer(1'b1, A_ST, 32'hFF);
      rd(A_ST, 32'h0);
      rd(16'h3D10, 32'h0);
      `CHK(rerr, 1'b1)
      $display("test shared address done");
      xfer(1'b1, A_IS, 32'hF8);
      xfer(1'b1, A_IM, 32'h80);
      rd(A_IM, 32'h80);
      frame({8'h33, 3'b001});
      `CHK(irq, 1'b1)
      rd(A_IS, 32'h80);
      xfer(1'b1, A_IS, 32'h80);
      `CHK(irq, 1'b0)
      xfer(1'b1, A_IM, 32'h0);
      frame({8'h44, 3'b001});
      `CHK(irq, 1'b0)
      rd(A_IS, 32'hA0);
      $display("test interrupt done");
      conclude();
   end
endmodule
`default_nettype wire
